// [include/mbi_params.svh]
// Purpose: Timing counts and field positions for the bus host controller.
// Assumes: SYS_CLK at 40 MHz.
// Notes:   Least times round up to whole clock cycles.
`ifndef MBI_PARAMS_SVH
`define MBI_PARAMS_SVH

`define MBI_CLK_NS       25
`define MBI_T_ALE_NS     50
`define MBI_T_AHOLD_NS   25
`define MBI_T_ACC_NS     100
`define MBI_T_WHOLD_NS   25
`define MBI_CYC_MIN(t)   (((t) + `MBI_CLK_NS - 1) / `MBI_CLK_NS)
`define MBI_ALE_CYC      `MBI_CYC_MIN(`MBI_T_ALE_NS)
`define MBI_AHOLD_CYC    `MBI_CYC_MIN(`MBI_T_AHOLD_NS)
`define MBI_ACC_CYC      `MBI_CYC_MIN(`MBI_T_ACC_NS)
`define MBI_WHOLD_CYC    `MBI_CYC_MIN(`MBI_T_WHOLD_NS)
`define MBI_ADDR_W       20
`define MBI_DATA_W       16
`define MBI_BURST_LSB    4
`define MBI_HI_LSB       16
`define MBI_MAX_BEATS    8

`endif

// [include/mbi_pkg.sv]
// Purpose: Types shared by the bus host controller and its lane steering.
// Assumes: Nothing beyond the parameter header.
// Notes:   The bus scheme is fixed at build time.
package mbi_pkg;

	typedef enum logic [2:0] {
		MBI_MUX_BHE   = 3'h0,
		MBI_MUX_WRLH  = 3'h1,
		MBI_NMX_SIZE  = 3'h2,
		MBI_NMX_UDLD  = 3'h3,
		MBI_NMX_OEWR  = 3'h4,
		MBI_MUX_BURST = 3'h5
	} mbi_mode_type;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_ADDR  = 6'h02,
		ST_LATCH = 6'h04,
		ST_STRB  = 6'h08,
		ST_HOLD  = 6'h10,
		ST_DONE  = 6'h20
	} mbi_state_type;

	// True for schemes that share address and data on one port.
	function automatic logic mbi_is_mux(input mbi_mode_type m);
		return (m == MBI_MUX_BHE) || (m == MBI_MUX_WRLH) ||
			(m == MBI_MUX_BURST);
	endfunction : mbi_is_mux

endpackage : mbi_pkg

// [include/mbi_lane_if.sv]
// Purpose: Carries access attributes to the lane steering and pin levels back.
// Assumes: Steering is purely combinational.
// Notes:   Control levels are active low except read/write select and size.
`timescale 1ns/1ps
interface mbi_lane_if;
	mbi_pkg::mbi_mode_type mode;
	logic                  wr;
	logic                  fetch;
	logic                  strb;
	logic [1:0]            be;
	logic [2:0]            cntl;
	logic                  pd3;
	logic                  a0;
	logic                  swap;

	modport ctl (output mode, wr, fetch, strb, be, input cntl, pd3, a0, swap);
	modport steer (input mode, wr, fetch, strb, be, output cntl, pd3, a0, swap);
endinterface : mbi_lane_if

// [verilog/mbi_lane_steer.sv]
// Purpose: Maps an access onto control pin levels and byte lanes.
// Assumes: be bit 0 is the even byte, bit 1 the odd byte, never both zero.
// Notes:   Big-endian schemes put the even byte on the upper lane.
`timescale 1ns/1ps
module mbi_lane_steer (
	mbi_lane_if.steer lif // Access attributes in, pin levels out.
);
	logic rd_s;
	logic wrl_s;
	logic wrh_s;

	// Qualified strobes shared by several schemes.
	always_comb begin
		rd_s  = lif.strb & ~lif.wr & ~lif.fetch;
		wrl_s = lif.strb & lif.wr & lif.be[0];
		wrh_s = lif.strb & lif.wr & lif.be[1];
	end

	// Even byte sits where address bit 0 is low.
	assign lif.a0 = ~lif.be[0];

	// Pin levels per scheme; idle strobes rest high, while enable, size and direction pins follow the attributes.
	always_comb begin
		lif.cntl = 3'h7;
		lif.pd3  = 1'b1;
		lif.swap = 1'b0;
		unique case (lif.mode)
			mbi_pkg::MBI_MUX_BHE: begin
				lif.cntl = {~lif.be[1], ~rd_s, ~(lif.strb & lif.wr)};
			end
			mbi_pkg::MBI_MUX_WRLH: begin
				lif.cntl = {1'b1, ~rd_s, ~wrl_s};
				lif.pd3  = ~wrh_s;
			end
			mbi_pkg::MBI_NMX_SIZE: begin
				lif.cntl = {~(&lif.be), ~lif.strb, ~lif.wr};
				lif.swap = 1'b1;
			end
			mbi_pkg::MBI_NMX_UDLD: begin
				// Upper strobe follows the odd byte enable, be[1].
				lif.cntl = {~(lif.strb & lif.be[1]),
					~(lif.strb & lif.be[0]), ~lif.wr};
				lif.swap = 1'b1;
			end
			mbi_pkg::MBI_NMX_OEWR: begin
				lif.cntl = {1'b1, ~rd_s, ~wrl_s};
				lif.pd3  = ~wrh_s;
			end
			mbi_pkg::MBI_MUX_BURST: begin
				// Fetches use their own strobe, reads the read strobe.
				lif.cntl = {~(lif.strb & lif.fetch), ~rd_s, ~wrl_s};
				lif.pd3  = ~wrh_s;
			end
			default: begin
				lif.cntl = 3'h7;
			end
		endcase
	end
endmodule : mbi_lane_steer

// [verilog/mbi_host_ctrl.sv]
// Purpose: Host-side bus controller for a flash peripheral's MCU port.
// Assumes: Device pins are sampled synchronously; one access at a time.
// Notes:   Every pin comes from a flip-flop; state pins change on the same edge as the state, attribute pins one edge after the attributes are caught.
`timescale 1ns/1ps
`include "mbi_params.svh"
module mbi_host_ctrl #(
	parameter mbi_pkg::mbi_mode_type BUS_MODE = mbi_pkg::MBI_MUX_BHE, // Scheme
	parameter bit                    USE_AS   = 1'b1 // Latch strobe, non-mux
) (
	input  wire logic        SYS_CLK,                   // 40 MHz clock.
	input  wire logic        ARST_N,                    // Async reset.
	input  wire logic        REQ,                       // Access request.
	input  wire logic        REQ_WR,                    // 1 write, 0 read.
	input  wire logic        REQ_FETCH,                 // Burst code fetch.
	input  wire logic [19:0] REQ_ADDR,                  // Byte address.
	input  wire logic [1:0]  REQ_BE,                    // Odd, even enable.
	input  wire logic [15:0] REQ_WDATA,                 // Odd, even byte.
	input  wire logic [2:0]  REQ_BEATS,                 // Fetch words - 1.
	output logic             BUSY,                      // Access running.
	output logic             RSP_VALID,                 // Read word pulse.
	output logic [15:0]      RSP_DATA,                  // Read word.
	output logic             DONE,                      // Access end pulse.
	input  wire logic [15:0] SHARED_ADDR_DATA_PORT_IN,  // Pin level.
	output logic [15:0]      SHARED_ADDR_DATA_PORT_OUT, // Pin drive.
	output logic             SHARED_ADDR_DATA_PORT_OE,  // Pin enable.
	input  wire logic [7:0]  PORT_F_IN,                 // Pin level.
	output logic [7:0]       PORT_F_OUT,                // Pin drive.
	output logic             PORT_F_OE,                 // Pin enable.
	input  wire logic [7:0]  PORT_G_IN,                 // Pin level.
	output logic [7:0]       PORT_G_OUT,                // Pin drive.
	output logic             PORT_G_OE,                 // Pin enable.
	output logic             CONTROL_INPUT_0,           // Control pin 0.
	output logic             CONTROL_INPUT_1,           // Control pin 1.
	output logic             CONTROL_INPUT_2,           // Control pin 2.
	output logic             PORT_D_BIT3,               // High write strobe.
	output logic             ADDRESS_STROBE_IN,         // Latch strobe.
	output logic [3:0]       ADDR_HI_OUT                // Address 19-16; zero in burst.
);
	localparam logic [3:0] ALE_CYC = 4'(`MBI_ALE_CYC);
	localparam logic [3:0] AH_CYC  = 4'(`MBI_AHOLD_CYC);
	localparam logic [3:0] ACC_CYC = 4'(`MBI_ACC_CYC);
	localparam logic [3:0] WH_CYC  = 4'(`MBI_WHOLD_CYC);
	localparam bit         MUXED   = mbi_pkg::mbi_is_mux(BUS_MODE);
	localparam bit         BURST   = (BUS_MODE == mbi_pkg::MBI_MUX_BURST);
	localparam bit         LATCH   = MUXED || USE_AS;

	mbi_pkg::mbi_state_type state_q;
	mbi_pkg::mbi_state_type state_d;
	logic        rst_meta_q;
	logic        rst_n_q;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [19:0] addr_q;
	logic [1:0]  be_q;
	logic        wr_q;
	logic        fetch_q;
	logic [15:0] wdata_q;
	logic [2:0]  left_q;
	logic [2:0]  a31_q;
	logic        beat_end;
	logic [15:0] wd_lane;
	logic [15:0] rd_bus;
	logic [15:0] rd_lane;
	logic        drive_data;
	mbi_lane_if  lif ();

	// Release the reset through two flops so it leaves clean.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Scheme is a build-time constant; nothing at run time can change it.
	assign lif.mode  = BUS_MODE;
	assign lif.wr    = wr_q;
	assign lif.fetch = fetch_q;
	assign lif.strb  = (state_d == mbi_pkg::ST_STRB);
	assign lif.be    = be_q;

	mbi_lane_steer u_steer (
		.lif (lif)
	);

	// Byte lanes swap for big-endian schemes, both directions alike.
	assign rd_bus = MUXED ? SHARED_ADDR_DATA_PORT_IN : {PORT_G_IN, PORT_F_IN};
	for (genvar g = 0; g < 2; g++) begin : g_lane
		assign wd_lane[g*8 +: 8] = lif.swap ? wdata_q[(1-g)*8 +: 8]
			: wdata_q[g*8 +: 8];
		assign rd_lane[g*8 +: 8] = lif.swap ? rd_bus[(1-g)*8 +: 8]
			: rd_bus[g*8 +: 8];
	end

	assign beat_end = (state_q == mbi_pkg::ST_STRB) && (cnt_q == 4'h0);

	// Sequencer: latch phase, strobe phase, then a write data hold phase.
	always_comb begin
		state_d = state_q;
		cnt_d   = (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
		unique case (state_q)
			mbi_pkg::ST_IDLE: begin
				if (REQ) begin
					state_d = LATCH ? mbi_pkg::ST_ADDR : mbi_pkg::ST_STRB;
					cnt_d   = LATCH ? ALE_CYC - 4'h1 : ACC_CYC;
				end
			end
			mbi_pkg::ST_ADDR: begin
				if (cnt_q == 4'h0) begin
					state_d = mbi_pkg::ST_LATCH;
					cnt_d   = AH_CYC - 4'h1;
				end
			end
			mbi_pkg::ST_LATCH: begin
				if (cnt_q == 4'h0) begin
					state_d = mbi_pkg::ST_STRB;
					cnt_d   = ACC_CYC;
				end
			end
			mbi_pkg::ST_STRB: begin
				if (cnt_q == 4'h0) begin
					// Burst beats restart the access timer.
					state_d = (left_q != 3'h0) ? mbi_pkg::ST_STRB
						: mbi_pkg::ST_HOLD;
					cnt_d   = (left_q != 3'h0) ? ACC_CYC : WH_CYC - 4'h1;
				end
			end
			mbi_pkg::ST_HOLD: begin
				if (cnt_q == 4'h0) begin
					state_d = mbi_pkg::ST_DONE;
				end
			end
			mbi_pkg::ST_DONE: begin
				state_d = mbi_pkg::ST_IDLE;
			end
		endcase
	end

	// State and phase counter.
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= mbi_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Access attributes are caught once; an empty enable means a word.
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			addr_q  <= 20'h00000;
			be_q    <= 2'h3;
			wr_q    <= 1'b0;
			fetch_q <= 1'b0;
			wdata_q <= 16'h0000;
			left_q  <= 3'h0;
			a31_q   <= 3'h0;
		end else if (state_q == mbi_pkg::ST_IDLE && REQ) begin
			addr_q  <= REQ_ADDR;
			be_q    <= (REQ_BE == 2'h0) ? 2'h3 : REQ_BE;
			wr_q    <= REQ_WR;
			fetch_q <= BURST && REQ_FETCH && !REQ_WR;
			wdata_q <= REQ_WDATA;
			left_q  <= (BURST && REQ_FETCH && !REQ_WR) ? REQ_BEATS : 3'h0;
			a31_q   <= REQ_ADDR[3:1];
		end else if (beat_end && left_q != 3'h0) begin
			left_q  <= left_q - 3'h1;
			a31_q   <= a31_q + 3'h1;
		end
	end

	assign drive_data = wr_q && (state_d == mbi_pkg::ST_STRB ||
		state_d == mbi_pkg::ST_HOLD);

	// Shared port: on mux buses address while latching, then write data or float.
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			SHARED_ADDR_DATA_PORT_OUT <= 16'h0000;
			SHARED_ADDR_DATA_PORT_OE  <= 1'b0;
		end else if (!MUXED) begin
			// Address only; data moves on F and G.
			SHARED_ADDR_DATA_PORT_OUT <= {addr_q[15:1], lif.a0};
			SHARED_ADDR_DATA_PORT_OE  <= (state_d != mbi_pkg::ST_IDLE);
		end else if (state_d == mbi_pkg::ST_ADDR ||
			state_d == mbi_pkg::ST_LATCH) begin
			// Held past the strobe's fall so the latch sees it stable.
			SHARED_ADDR_DATA_PORT_OUT <= BURST ? addr_q[19:4]
				: {addr_q[15:1], lif.a0};
			SHARED_ADDR_DATA_PORT_OE  <= 1'b1;
		end else begin
			SHARED_ADDR_DATA_PORT_OUT <= wd_lane;
			SHARED_ADDR_DATA_PORT_OE  <= drive_data;
		end
	end

	// Ports F and G: data lanes on non-mux buses, burst bits 3-1 on F.
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			PORT_F_OUT <= 8'h00;
			PORT_F_OE  <= 1'b0;
			PORT_G_OUT <= 8'h00;
			PORT_G_OE  <= 1'b0;
		end else if (BURST) begin
			PORT_F_OUT <= {5'h00, a31_q};
			PORT_F_OE  <= (state_d != mbi_pkg::ST_IDLE);
			PORT_G_OUT <= 8'h00;
			PORT_G_OE  <= 1'b0;
		end else begin
			PORT_F_OUT <= wd_lane[7:0];
			PORT_F_OE  <= !MUXED && drive_data;
			PORT_G_OUT <= wd_lane[15:8];
			PORT_G_OE  <= !MUXED && drive_data;
		end
	end

	// Control strobes rise before data is released, giving hold time.
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			CONTROL_INPUT_0   <= 1'b1;
			CONTROL_INPUT_1   <= 1'b1;
			CONTROL_INPUT_2   <= 1'b1;
			PORT_D_BIT3       <= 1'b1;
			ADDRESS_STROBE_IN <= 1'b0;
			ADDR_HI_OUT       <= 4'h0;
		end else begin
			CONTROL_INPUT_0   <= lif.cntl[0];
			CONTROL_INPUT_1   <= lif.cntl[1];
			CONTROL_INPUT_2   <= lif.cntl[2];
			PORT_D_BIT3       <= lif.pd3;
			ADDRESS_STROBE_IN <= LATCH && (state_d == mbi_pkg::ST_ADDR);
			ADDR_HI_OUT       <= BURST ? 4'h0 : addr_q[19:16];
		end
	end

	// Responses: read words at each beat end, one done pulse per access.
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			RSP_VALID <= 1'b0;
			RSP_DATA  <= 16'h0000;
			DONE      <= 1'b0;
			BUSY      <= 1'b0;
		end else begin
			RSP_VALID <= beat_end && !wr_q;
			if (beat_end && !wr_q) begin
				RSP_DATA <= rd_lane;
			end
			DONE <= (state_q == mbi_pkg::ST_DONE);
			BUSY <= (state_d != mbi_pkg::ST_IDLE);
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!rst_n_q);

	property p_addr_latched;
		$fell(ADDRESS_STROBE_IN) |-> SHARED_ADDR_DATA_PORT_OE &&
			$stable(SHARED_ADDR_DATA_PORT_OUT);
	endproperty
	a_addr_latched: assert property (p_addr_latched)
		else $error("Address changed at latch strobe fall.");

	property p_no_drive_read;
		(state_q == mbi_pkg::ST_STRB && !wr_q) |=>
			!SHARED_ADDR_DATA_PORT_OE || !MUXED;
	endproperty
	a_no_drive_read: assert property (p_no_drive_read)
		else $error("Host drives shared port during a read.");

	property p_float_idle;
		(state_q == mbi_pkg::ST_IDLE && $past(state_q) == mbi_pkg::ST_IDLE)
			|-> !PORT_G_OE && !PORT_F_OE;
	endproperty
	a_float_idle: assert property (p_float_idle)
		else $error("Data ports driven while idle.");

	property p_burst_addr;
		(BURST && state_q == mbi_pkg::ST_ADDR) |=>
			SHARED_ADDR_DATA_PORT_OUT == addr_q[19:4];
	endproperty
	a_burst_addr: assert property (p_burst_addr)
		else $error("Burst address phase not bits 19-4.");

	// Pins trail the attributes by one edge, so the first strobe cycle is
	// left out; the last strobe cycle still shows the strobe low.
	property p_size_bit;
		(BUS_MODE == mbi_pkg::MBI_NMX_SIZE && state_q == mbi_pkg::ST_STRB &&
			$past(state_q) == mbi_pkg::ST_STRB)
			|-> CONTROL_INPUT_2 == !(&be_q) && !CONTROL_INPUT_1;
	endproperty
	a_size_bit: assert property (p_size_bit)
		else $error("Size bit or data strobe wrong.");

	property p_bhe_lane;
		(BUS_MODE == mbi_pkg::MBI_MUX_BHE && state_q == mbi_pkg::ST_ADDR)
			|=> SHARED_ADDR_DATA_PORT_OUT[0] == !be_q[0];
	endproperty
	a_bhe_lane: assert property (p_bhe_lane)
		else $error("Address bit 0 disagrees with byte enables.");

	property p_burst_step;
		(beat_end && left_q != 3'h0) |=> a31_q == $past(a31_q) + 3'h1
			##1 PORT_F_OUT[2:0] == a31_q;
	endproperty
	a_burst_step: assert property (p_burst_step)
		else $error("Burst low address did not step.");

	property p_done_bound;
		(state_q == mbi_pkg::ST_IDLE && REQ) |-> ##[4:80] DONE;
	endproperty
	a_done_bound: assert property (p_done_bound)
		else $error("Access did not finish in time.");

	// The write strobe sits on pin 1 in the size-bit scheme, on pins 1 and 2 in the UDLD scheme, else on pin 0.
	property p_wr_hold;
		(state_q == mbi_pkg::ST_HOLD && wr_q) |-> PORT_D_BIT3 &&
			(BUS_MODE == mbi_pkg::MBI_NMX_SIZE ? CONTROL_INPUT_1 :
			BUS_MODE == mbi_pkg::MBI_NMX_UDLD ?
			CONTROL_INPUT_1 && CONTROL_INPUT_2 : CONTROL_INPUT_0) &&
			(SHARED_ADDR_DATA_PORT_OE || PORT_F_OE || PORT_G_OE);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("Write data released with strobe.");
endmodule : mbi_host_ctrl

// [sim/mbi_dev_model.sv]
// Purpose: Behavioural peripheral port in the high-byte-enable mux scheme.
// Assumes: Write, read and byte enable strobes are active low.
// Notes:   Sixteen words only; the scheme is fixed, only the region is a parameter.
`timescale 1ns/1ps
module mbi_dev_model #(
	parameter logic [3:0] HI_SEL = 4'h1 // Upper address region decoded.
) (
	input  wire logic [15:0] ad,       // Shared port level.
	input  wire logic        ale,      // Latch strobe, active high.
	input  wire logic        wr_n,     // Write strobe.
	input  wire logic        rd_n,     // Read strobe.
	input  wire logic        hbe_n,    // High byte enable.
	input  wire logic [3:0]  a_hi,     // Extra address inputs.
	output logic [15:0]      dq,       // Read drive.
	output logic             dq_oe,    // High while the model drives.
	output logic [15:0]      lat_addr  // Latched address out.
);
	logic [15:0] mem [0:15];
	logic [15:0] wbuf;
	logic        sel;

	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
	end

	// Address taken as the strobe falls and kept until the next pulse.
	always @(negedge ale) lat_addr <= ad;

	// Upper pins join the decode, so a wrong region is ignored.
	assign sel = (a_hi == HI_SEL) && (lat_addr[15:5] == 11'h000);

	// Drive only on own reads; otherwise the port is left to others.
	assign dq_oe = (sel === 1'b1) && !rd_n;
	assign dq    = mem[lat_addr[4:1]];

	// Data follows the port while the strobe is low, so the commit at the
	// rising strobe does not race a change of the host drive.
	always @* if (!wr_n) wbuf = ad;
	always @(posedge wr_n) begin
		if (sel === 1'b1) begin
			if (!hbe_n) mem[lat_addr[4:1]][15:8] <= wbuf[15:8];
			if (!lat_addr[0]) mem[lat_addr[4:1]][7:0] <= wbuf[7:0];
		end
	end
endmodule : mbi_dev_model

// [sim/tb_mbi_host_ctrl.sv]
// Purpose: Self-checking bench for the host controller in the high-byte-enable mux and size-bit schemes.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Expected data is worked out from the writes made, or from the twin's fixed lane pattern.
`timescale 1ns/1ps
module tb_mbi_host_ctrl;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        req = 1'b0;
	logic        req_wr = 1'b0;
	logic [19:0] req_addr = 20'h00000;
	logic [1:0]  req_be = 2'h3;
	logic [15:0] req_wdata = 16'h0000;
	logic        busy, rsp_valid, done, ad_oe, f_oe, g_oe;
	logic [15:0] rsp_data, ad_out, ad_in, dq, lat_addr;
	logic [7:0]  f_out, g_out, f_in, g_in;
	logic        c0, c1, c2, pd3, strobe, dq_oe;
	logic [3:0]  addr_hi;
	logic        n_busy, n_rsp_valid, n_done, n_ad_oe, n_f_oe, n_g_oe;
	logic        n_c0, n_c1, n_c2, n_pd3, n_as;
	logic [15:0] n_rsp, n_ad_out;
	logic [7:0]  n_f_out, n_g_out;
	logic [3:0]  n_addr_hi;
	logic        tog = 1'b0;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cycles = 0;

	always #12.5 sys_clk = ~sys_clk;

	// Undriven lines show a pattern that changes each cycle, not stale data.
	always @(posedge sys_clk) tog <= ~tog;
	assign ad_in = ad_oe ? ad_out : (dq_oe ? dq : {16{tog}} ^ 16'hA5A5);
	assign f_in  = f_oe ? f_out : {8{tog}};
	assign g_in  = g_oe ? g_out : {8{~tog}};

	// Each instance fixes its scheme; nothing switches it at run time.
	mbi_host_ctrl #(.BUS_MODE(mbi_pkg::MBI_MUX_BHE), .USE_AS(1'b1)) u_dut (
		.SYS_CLK(sys_clk), .ARST_N(arst_n), .REQ(req), .REQ_WR(req_wr),
		.REQ_FETCH(1'b0), .REQ_ADDR(req_addr), .REQ_BE(req_be),
		.REQ_WDATA(req_wdata), .REQ_BEATS(3'h0), .BUSY(busy),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .DONE(done),
		.SHARED_ADDR_DATA_PORT_IN(ad_in), .SHARED_ADDR_DATA_PORT_OUT(ad_out),
		.SHARED_ADDR_DATA_PORT_OE(ad_oe), .PORT_F_IN(f_in),
		.PORT_F_OUT(f_out), .PORT_F_OE(f_oe), .PORT_G_IN(g_in),
		.PORT_G_OUT(g_out), .PORT_G_OE(g_oe), .CONTROL_INPUT_0(c0),
		.CONTROL_INPUT_1(c1), .CONTROL_INPUT_2(c2), .PORT_D_BIT3(pd3),
		.ADDRESS_STROBE_IN(strobe), .ADDR_HI_OUT(addr_hi)
	);

	// Size-bit scheme twin shares the request port; its data lanes read a
	// fixed pattern so that lane swapping shows in the read word.
	mbi_host_ctrl #(.BUS_MODE(mbi_pkg::MBI_NMX_SIZE), .USE_AS(1'b0)) u_nmx (
		.SYS_CLK(sys_clk), .ARST_N(arst_n), .REQ(req), .REQ_WR(req_wr),
		.REQ_FETCH(1'b0), .REQ_ADDR(req_addr), .REQ_BE(req_be),
		.REQ_WDATA(req_wdata), .REQ_BEATS(3'h0), .BUSY(n_busy),
		.RSP_VALID(n_rsp_valid), .RSP_DATA(n_rsp), .DONE(n_done),
		.SHARED_ADDR_DATA_PORT_IN(n_ad_out),
		.SHARED_ADDR_DATA_PORT_OUT(n_ad_out),
		.SHARED_ADDR_DATA_PORT_OE(n_ad_oe), .PORT_F_IN(8'h3C),
		.PORT_F_OUT(n_f_out), .PORT_F_OE(n_f_oe), .PORT_G_IN(8'hC3),
		.PORT_G_OUT(n_g_out), .PORT_G_OE(n_g_oe), .CONTROL_INPUT_0(n_c0),
		.CONTROL_INPUT_1(n_c1), .CONTROL_INPUT_2(n_c2), .PORT_D_BIT3(n_pd3),
		.ADDRESS_STROBE_IN(n_as), .ADDR_HI_OUT(n_addr_hi)
	);

	mbi_dev_model #(.HI_SEL(4'h1)) u_dev (
		.ad(ad_in), .ale(strobe), .wr_n(c0), .rd_n(c1), .hbe_n(c2),
		.a_hi(addr_hi), .dq(dq), .dq_oe(dq_oe), .lat_addr(lat_addr)
	);

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// One access; the walk counts falling edges from the take to DONE.
	task automatic op(input logic wr, input logic [19:0] a,
		input logic [1:0] be, input logic [15:0] wd, input logic [15:0] m,
		input logic [15:0] la);
		logic [15:0] rd;
		logic [15:0] nrd;
		int          n;
		int          nlen;
		rd   = 16'hXXXX;
		nrd  = 16'hXXXX;
		nlen = 0;
		@(negedge sys_clk);
		{req, req_wr, req_addr, req_be, req_wdata} = {1'b1, wr, a, be, wd};
		@(negedge sys_clk);
		req = 1'b0;
		check({15'h0000, busy}, 16'h0001, "busy after take");
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			if (rsp_valid === 1'b1) rd = rsp_data;
			if (n_rsp_valid === 1'b1) nrd = n_rsp;
			if (n_done === 1'b1) nlen = n;
			if (n == 2) check_nmx(wr, a, be, wd);
			check({15'h0000, ad_oe & dq_oe}, 16'h0000, "port contention");
			@(negedge sys_clk);
			n++;
		end
		check(16'(n), 16'h000A, "access length");
		check(lat_addr, la, "latched address");
		if (!wr) check(rd & m, wd & m, "read data");
		check(16'(nlen), 16'h0007, "unlatched access length");
		check(16'({n_busy, n_f_oe, n_g_oe}), 16'h0000, "idle lanes");
		if (!wr) check(nrd & m, 16'h3CC3 & m, "swapped read");
	endtask : op

	// Size-bit scheme pins mid-strobe; the even byte rides the upper lane.
	task automatic check_nmx(input logic wr, input logic [19:0] a,
		input logic [1:0] be, input logic [15:0] wd);
		logic [15:0] lm;
		logic [15:0] pins;
		logic [15:0] pe;
		lm   = {{8{be[0]}}, {8{be[1]}}};
		pins = {10'h000, n_pd3, n_as, n_c0, n_c1, n_c2, n_ad_oe};
		pe   = {10'h000, 1'b1, 1'b0, !wr, 1'b0, !(&be), 1'b1};
		check(pins, pe, "size-bit pins");
		check(n_ad_out, {a[15:1], !be[0]}, "address port");
		check({14'h0000, n_f_oe, n_g_oe}, {14'h0000, wr, wr}, "lane oe");
		pe = {wd[7:0], wd[15:8]} & lm;
		if (wr) check({n_g_out, n_f_out} & lm, pe, "data lanes");
		check(16'(n_addr_hi), 16'(a[19:16]), "upper address");
	endtask : check_nmx

	task automatic check_reset();
		check({11'h000, ad_oe, c0, c1, c2, busy}, 16'h000E, "reset levels");
	endtask : check_reset

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			$display("CHECK FAILED %0t run did not finish", $time);
			finish_test();
		end
	end

	initial begin
		repeat (8) @(negedge sys_clk);
		check_reset();
		arst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		op(1'b1, 20'h10002, 2'b11, 16'h1234, 16'h0000, 16'h0002);
		op(1'b1, 20'h10002, 2'b10, 16'hAB00, 16'h0000, 16'h0003);
		op(1'b1, 20'h10002, 2'b01, 16'h00CD, 16'h0000, 16'h0002);
		op(1'b1, 20'h20002, 2'b11, 16'hFFFF, 16'h0000, 16'h0002);
		op(1'b1, 20'h1001E, 2'b11, 16'h5AC3, 16'h0000, 16'h001E);
		op(1'b0, 20'h10002, 2'b11, 16'hABCD, 16'hFFFF, 16'h0002);
		op(1'b0, 20'h10002, 2'b10, 16'hAB00, 16'hFF00, 16'h0003);
		op(1'b0, 20'h10002, 2'b01, 16'h00CD, 16'h00FF, 16'h0002);
		op(1'b0, 20'h1001E, 2'b11, 16'h5AC3, 16'hFFFF, 16'h001E);
		// A read cut short by reset; REQ held high meanwhile is refused.
		@(negedge sys_clk);
		{req, req_wr, req_addr, req_be} = {1'b1, 1'b0, 20'h1001E, 2'b11};
		repeat (5) @(negedge sys_clk);
		req = 1'b0;
		arst_n = 1'b0;
		#1 check_reset();
		repeat (8) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		op(1'b0, 20'h10002, 2'b11, 16'hABCD, 16'hFFFF, 16'h0002);
		finish_test();
	end
endmodule : tb_mbi_host_ctrl
